// ===== core/cpcd_pkg.sv
// constants shared by the calibration and pin command decoder
package cpcd_pkg;
  // =========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] CPCD_OFS_COMMAND  = 8'h10;
  localparam logic [7:0] CPCD_OFS_PARAM0   = 8'h14;
  localparam logic [7:0] CPCD_OFS_STATUS   = 8'h18;
  localparam logic [7:0] CPCD_OFS_PINS     = 8'h1C;
  localparam logic [3:0] CPCD_CAL_PAGE     = 4'h2;
  // =========================================================
  // calibration area: fourteen bytes packed into four words
  localparam int unsigned CPCD_CAL_WORDS   = 4;
  localparam logic [3:0]  CPCD_CAL_LAST    = 4'hD;
  localparam logic [1:0]  CPCD_LOAD_LAST   = 2'h3;
  localparam logic [31:0] CPCD_TAIL_MASK   = 32'h0000_FFFF;
  // =========================================================
  // command codes
  localparam logic [7:0] CPCD_CMD_FACT_CAL = 8'h0A;
  localparam logic [7:0] CPCD_CMD_LOAD_CAL = 8'h0B;
  localparam logic [7:0] CPCD_CMD_PIN_CFG  = 8'h0F;
  // =========================================================
  // auxiliary pin codes
  localparam logic [3:0] CPCD_PIN_OFF      = 4'h0;
  localparam logic [3:0] CPCD_PIN_INH_LO   = 4'h1;
  localparam logic [3:0] CPCD_PIN_INH_HI   = 4'h2;
  localparam logic [3:0] CPCD_PIN_LASER    = 4'h3;
  localparam logic [3:0] CPCD_PIN_DRV_LO   = 4'h4;
  localparam logic [3:0] CPCD_PIN_DRV_HI   = 4'h5;
  // =========================================================
  // reset values and field positions
  localparam logic [7:0] CPCD_RST_COMMAND  = 8'h00;
  localparam logic [7:0] CPCD_RST_PARAM0   = 8'h00;
  localparam logic [3:0] CPCD_RST_PIN_CFG  = CPCD_PIN_DRV_LO;
  localparam int unsigned CPCD_PRM_FACT    = 0;
  localparam int unsigned CPCD_PRM_ALGO    = 1;
  localparam int unsigned CPCD_ST_BUSY     = 0;
  localparam int unsigned CPCD_ST_CALDONE  = 1;
  localparam int unsigned CPCD_ST_FACT     = 2;
  localparam int unsigned CPCD_ST_ALGO     = 3;
  localparam int unsigned CPCD_ST_LDDONE   = 4;
  localparam logic [1:0] CPCD_RESP_OKAY    = 2'b00;
  localparam logic [1:0] CPCD_RESP_SLVERR  = 2'b10;
  // =========================================================
  // sequencer states
  typedef enum logic [1:0] {
    CPCD_IDLE = 2'b00,
    CPCD_CAL  = 2'b01,
    CPCD_LOAD = 2'b11
  } cpcd_state_e;
endpackage : cpcd_pkg

// ===== core/cpcd_cal_mem.sv
// word memory for calibration data, byte-lane writes and registered read
module cpcd_cal_mem #(
  parameter int unsigned WORDS = 4,
  parameter int unsigned AW    = 2
) (
  // clocking
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [3:0]    wbe,
  input  wire logic [31:0]   wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata_ff
);
  logic [31:0] mem [WORDS];

  if (WORDS > (1 << AW)) begin : g_bad_depth
    $error("cpcd_cal_mem: WORDS exceeds address range");
  end

  // array has no reset: contents are undefined until written
  always_ff @(posedge clk) begin
    if (ce && we) begin
      for (int b = 0; b < 4; b++) begin
        if (wbe[b]) begin
          mem[waddr][8*b +: 8] <= wdata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      rdata_ff <= mem[raddr];
    end
  end
endmodule : cpcd_cal_mem

// ===== core/cpcd_decoder.sv
// command decoder for factory calibration, calibration download and aux pin setup
// Operation
// - command 0x0A starts a factory calibration run
// - calibration result lands in fourteen bytes from address 0x20
// - command 0x0B loads host-supplied calibration data, as parameter byte zero selects
// - parameter bit 0 marks data at 0x20 as factory calibration values
// - command 0x0F applies pin setup without starting a measurement
// - pin 0 code in parameter bits 3:0, pin 1 code in bits 7:4
// - codes 0 off, 3 laser pulse, 4 drive low, 5 drive high
// - code 1 low level aborts and blocks collection, rising restarts
// - code 2 high level aborts and blocks collection, falling restarts
//
// The AXI4-Lite slave port was chosen for this implementation.
module cpcd_decoder
  import cpcd_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // clock, reset, enable
  input  wire logic              SYS_CLK,
  input  wire logic              RESET,
  input  wire logic              CE,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic      [1:0]        S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic      [31:0]       S_AXI_RDATA,
  output logic      [1:0]        S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // calibration engine
  output logic                   CAL_START,
  input  wire logic              CAL_BYTE_VALID,
  input  wire logic [7:0]        CAL_BYTE,
  output logic                   CAL_DONE,
  // download stream to the algorithm core
  output logic                   LOAD_VALID,
  output logic      [1:0]        LOAD_INDEX,
  output logic      [31:0]       LOAD_WORD,
  output logic                   FACTORY_CAL_PRESENT,
  output logic                   ALGO_STATE_PRESENT,
  // auxiliary pins and laser timing
  input  wire logic              LASER_PULSE,
  input  wire logic              AUX_PIN0_IN,
  output logic                   AUX_PIN0_OUT,
  output logic                   AUX_PIN0_OE,
  input  wire logic              AUX_PIN1_IN,
  output logic                   AUX_PIN1_OUT,
  output logic                   AUX_PIN1_OE,
  // measurement control
  output logic                   MEAS_ABORT,
  output logic                   MEAS_RESTART,
  output logic                   COLLECT_BLOCK
);
  if (ADDR_W < 8) begin : g_bad_aw
    $error("cpcd_decoder: ADDR_W must be at least 8");
  end

  // =========================================================
  // helpers
  function automatic logic is_cal(input logic [7:0] a);
    return a[7:4] == CPCD_CAL_PAGE;
  endfunction : is_cal

  function automatic logic [31:0] cal_mask(input logic [1:0] idx, input logic [31:0] d);
    return (idx == CPCD_LOAD_LAST) ? (d & CPCD_TAIL_MASK) : d;
  endfunction : cal_mask

  // returns {oe, level}; reserved codes leave the pin undriven
  function automatic logic [1:0] pin_drive(input logic [3:0] cfg, input logic laser);
    case (cfg)
      CPCD_PIN_LASER:  return {1'b1, laser};
      CPCD_PIN_DRV_LO: return 2'b10;
      CPCD_PIN_DRV_HI: return 2'b11;
      default:         return 2'b00;
    endcase
  endfunction : pin_drive

  function automatic logic pin_inh(input logic [3:0] cfg, input logic lvl);
    return ((cfg == CPCD_PIN_INH_LO) && !lvl) || ((cfg == CPCD_PIN_INH_HI) && lvl);
  endfunction : pin_inh

  // =========================================================
  // state
  cpcd_state_e state_ff, nxt_state;
  logic              aw_held_ff, w_held_ff, aw_rdy_ff, w_rdy_ff, bvalid_ff;
  logic [7:0]        awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic [1:0]        bresp_ff;
  logic              rd_pend_ff, rvalid_ff, ar_rdy_ff;
  logic [7:0]        rdaddr_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic [7:0]        command_ff, param0_ff;
  logic [3:0]        pin0_cfg_ff, pin1_cfg_ff, cal_cnt_ff;
  logic              cal_done_ff, load_done_ff, fact_ff, algo_ff, cal_start_ff, cal_pulse_ff;
  logic [1:0]        ld_idx_ff, ld_q_idx_ff, load_index_ff;
  logic              ld_q_vld_ff, load_valid_ff;
  logic [31:0]       load_word_ff, mem_q;
  logic [1:0]        sync1_ff, sync2_ff, oe_ff, out_ff;
  logic              block_ff, abort_ff, restart_ff;

  // =========================================================
  // write channel decode
  wire        aw_hs       = S_AXI_AWVALID && aw_rdy_ff;
  wire        w_hs        = S_AXI_WVALID && w_rdy_ff;
  wire        do_wr       = aw_held_ff && w_held_ff && !bvalid_ff;
  wire        nxt_aw_held = (aw_held_ff || aw_hs) && !do_wr;
  wire        nxt_w_held  = (w_held_ff || w_hs) && !do_wr;
  wire        nxt_bvalid  = do_wr || (bvalid_ff && !S_AXI_BREADY);
  wire        idle        = state_ff == CPCD_IDLE;
  wire        wr_cmd      = do_wr && awaddr_ff == CPCD_OFS_COMMAND && wstrb_ff[0];
  wire        wr_param    = do_wr && awaddr_ff == CPCD_OFS_PARAM0 && wstrb_ff[0];
  wire        wr_cal      = do_wr && is_cal(awaddr_ff) && state_ff != CPCD_CAL;
  wire        wr_mapped   = is_cal(awaddr_ff) || awaddr_ff == CPCD_OFS_COMMAND ||
                            awaddr_ff == CPCD_OFS_PARAM0 || awaddr_ff == CPCD_OFS_STATUS ||
                            awaddr_ff == CPCD_OFS_PINS;
  // commands arriving while a sequence runs are dropped
  wire        cmd_go      = wr_cmd && idle;
  wire [7:0]  cmd_byte    = wdata_ff[7:0];
  wire        go_cal      = cmd_go && cmd_byte == CPCD_CMD_FACT_CAL;
  wire        go_load     = cmd_go && cmd_byte == CPCD_CMD_LOAD_CAL;
  wire        go_pins     = cmd_go && cmd_byte == CPCD_CMD_PIN_CFG;

  // =========================================================
  // sequencer and memory ports
  wire        cal_we      = state_ff == CPCD_CAL && CAL_BYTE_VALID;
  wire        cal_end     = cal_we && cal_cnt_ff == CPCD_CAL_LAST;
  wire        ld_end      = state_ff == CPCD_LOAD && ld_idx_ff == CPCD_LOAD_LAST;
  wire        mem_we      = cal_we || wr_cal;
  wire [1:0]  mem_waddr   = cal_we ? cal_cnt_ff[3:2] : awaddr_ff[3:2];
  wire [3:0]  mem_wbe     = cal_we ? (4'h1 << cal_cnt_ff[1:0]) : wstrb_ff;
  wire [31:0] mem_wdata   = cal_we ? {4{CAL_BYTE}} : wdata_ff;
  wire        ar_hs       = S_AXI_ARVALID && ar_rdy_ff;
  wire [1:0]  mem_raddr   = (state_ff == CPCD_LOAD) ? ld_idx_ff : S_AXI_ARADDR[3:2];
  wire        nxt_rvalid  = rd_pend_ff || (rvalid_ff && !S_AXI_RREADY);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CPCD_IDLE: begin
        if (go_cal) begin
          nxt_state = CPCD_CAL;
        end else if (go_load && param0_ff[CPCD_PRM_FACT]) begin
          nxt_state = CPCD_LOAD;
        end
      end
      CPCD_CAL:  nxt_state = cal_end ? CPCD_IDLE : CPCD_CAL;
      CPCD_LOAD: nxt_state = ld_end ? CPCD_IDLE : CPCD_LOAD;
      default:   nxt_state = CPCD_IDLE;
    endcase
  end

  cpcd_cal_mem #(.WORDS(CPCD_CAL_WORDS), .AW(2)) u_mem (
    .clk      (SYS_CLK),
    .rst      (RESET),
    .ce       (CE),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wbe      (mem_wbe),
    .wdata    (mem_wdata),
    .raddr    (mem_raddr),
    .rdata_ff (mem_q)
  );

  // =========================================================
  // read data selection
  wire [31:0] status_w = {27'h000_0000, load_done_ff, algo_ff, fact_ff, cal_done_ff, !idle};
  wire [31:0] pins_w   = {16'h0000, 2'b00, sync2_ff, 2'b00, block_ff, 1'b0, pin1_cfg_ff, pin0_cfg_ff};
  wire        rd_cal   = is_cal(rdaddr_ff);
  wire        rd_map   = rd_cal || rdaddr_ff == CPCD_OFS_COMMAND || rdaddr_ff == CPCD_OFS_PARAM0 ||
                         rdaddr_ff == CPCD_OFS_STATUS || rdaddr_ff == CPCD_OFS_PINS;
  wire [31:0] rd_word  = rd_cal                          ? cal_mask(rdaddr_ff[3:2], mem_q) :
                         rdaddr_ff == CPCD_OFS_COMMAND   ? {24'h00_0000, command_ff} :
                         rdaddr_ff == CPCD_OFS_PARAM0    ? {24'h00_0000, param0_ff} :
                         rdaddr_ff == CPCD_OFS_STATUS    ? status_w :
                         rdaddr_ff == CPCD_OFS_PINS      ? pins_w : 32'h0000_0000;

  // =========================================================
  // pins: inhibit from synchronised levels, drive from config
  wire [1:0] drv0  = pin_drive(pin0_cfg_ff, LASER_PULSE);
  wire [1:0] drv1  = pin_drive(pin1_cfg_ff, LASER_PULSE);
  wire       inh_w = pin_inh(pin0_cfg_ff, sync2_ff[0]) || pin_inh(pin1_cfg_ff, sync2_ff[1]);

  // =========================================================
  // bus registers
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_rdy_ff  <= 1'b0;
      w_rdy_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= CPCD_RESP_OKAY;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      rd_pend_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      ar_rdy_ff  <= 1'b0;
      rdaddr_ff  <= 8'h00;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= CPCD_RESP_OKAY;
    end else if (CE) begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      aw_rdy_ff  <= !nxt_aw_held && !nxt_bvalid;
      w_rdy_ff   <= !nxt_w_held && !nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      if (aw_hs) awaddr_ff <= S_AXI_AWADDR[7:0];
      if (w_hs) begin
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
      end
      if (do_wr) bresp_ff <= wr_mapped ? CPCD_RESP_OKAY : CPCD_RESP_SLVERR;
      rd_pend_ff <= ar_hs;
      rvalid_ff  <= nxt_rvalid;
      // no reads during download: the memory read port belongs to the stream
      ar_rdy_ff  <= !ar_hs && !nxt_rvalid && nxt_state != CPCD_LOAD;
      if (ar_hs) rdaddr_ff <= S_AXI_ARADDR[7:0];
      if (rd_pend_ff) begin
        rdata_ff <= rd_word;
        rresp_ff <= rd_map ? CPCD_RESP_OKAY : CPCD_RESP_SLVERR;
      end
    end
  end

  // =========================================================
  // command and sequencer registers
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      state_ff     <= CPCD_IDLE;
      command_ff   <= CPCD_RST_COMMAND;
      param0_ff    <= CPCD_RST_PARAM0;
      pin0_cfg_ff  <= CPCD_RST_PIN_CFG;
      pin1_cfg_ff  <= CPCD_RST_PIN_CFG;
      cal_cnt_ff   <= 4'h0;
      cal_done_ff  <= 1'b0;
      load_done_ff <= 1'b0;
      fact_ff      <= 1'b0;
      algo_ff      <= 1'b0;
      cal_start_ff <= 1'b0;
      cal_pulse_ff <= 1'b0;
      ld_idx_ff    <= 2'h0;
    end else if (CE) begin
      state_ff     <= nxt_state;
      if (cmd_go) command_ff <= cmd_byte;
      if (wr_param) param0_ff <= wdata_ff[7:0];
      cal_start_ff <= go_cal;
      cal_pulse_ff <= cal_end;
      if (go_cal) cal_cnt_ff <= 4'h0;
      else if (cal_we) cal_cnt_ff <= cal_cnt_ff + 4'h1;
      cal_done_ff  <= cal_end || (cal_done_ff && !go_cal);
      if (go_load) begin
        fact_ff <= param0_ff[CPCD_PRM_FACT];
        // algorithm state without the factory flag is not trusted
        algo_ff <= param0_ff[CPCD_PRM_FACT] && param0_ff[CPCD_PRM_ALGO];
      end
      load_done_ff <= ld_end || (go_load && !param0_ff[CPCD_PRM_FACT]) || (load_done_ff && !go_load);
      if (go_load) ld_idx_ff <= 2'h0;
      else if (state_ff == CPCD_LOAD) ld_idx_ff <= ld_idx_ff + 2'h1;
      if (go_pins) begin
        pin0_cfg_ff <= param0_ff[3:0];
        pin1_cfg_ff <= param0_ff[7:4];
      end
    end
  end

  // =========================================================
  // download stream and pin registers
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ld_q_vld_ff   <= 1'b0;
      ld_q_idx_ff   <= 2'h0;
      load_valid_ff <= 1'b0;
      load_index_ff <= 2'h0;
      load_word_ff  <= 32'h0000_0000;
      sync1_ff      <= 2'b00;
      sync2_ff      <= 2'b00;
      oe_ff         <= 2'b00;
      out_ff        <= 2'b00;
      block_ff      <= 1'b0;
      abort_ff      <= 1'b0;
      restart_ff    <= 1'b0;
    end else if (CE) begin
      ld_q_vld_ff   <= state_ff == CPCD_LOAD;
      ld_q_idx_ff   <= ld_idx_ff;
      load_valid_ff <= ld_q_vld_ff;
      load_index_ff <= ld_q_idx_ff;
      if (ld_q_vld_ff) load_word_ff <= cal_mask(ld_q_idx_ff, mem_q);
      sync1_ff      <= {AUX_PIN1_IN, AUX_PIN0_IN};
      sync2_ff      <= sync1_ff;
      oe_ff         <= {drv1[1], drv0[1]};
      out_ff        <= {drv1[0], drv0[0]};
      block_ff      <= inh_w;
      abort_ff      <= inh_w && !block_ff;
      restart_ff    <= !inh_w && block_ff;
    end
  end

  // =========================================================
  // outputs
  assign S_AXI_AWREADY       = aw_rdy_ff;
  assign S_AXI_WREADY        = w_rdy_ff;
  assign S_AXI_BVALID        = bvalid_ff;
  assign S_AXI_BRESP         = bresp_ff;
  assign S_AXI_ARREADY       = ar_rdy_ff;
  assign S_AXI_RVALID        = rvalid_ff;
  assign S_AXI_RDATA         = rdata_ff;
  assign S_AXI_RRESP         = rresp_ff;
  assign CAL_START           = cal_start_ff;
  assign CAL_DONE            = cal_pulse_ff;
  assign LOAD_VALID          = load_valid_ff;
  assign LOAD_INDEX          = load_index_ff;
  assign LOAD_WORD           = load_word_ff;
  assign FACTORY_CAL_PRESENT = fact_ff;
  assign ALGO_STATE_PRESENT  = algo_ff;
  assign AUX_PIN0_OE         = oe_ff[0];
  assign AUX_PIN0_OUT        = out_ff[0];
  assign AUX_PIN1_OE         = oe_ff[1];
  assign AUX_PIN1_OUT        = out_ff[1];
  assign COLLECT_BLOCK       = block_ff;
  assign MEAS_ABORT          = abort_ff;
  assign MEAS_RESTART        = restart_ff;

  // =========================================================
  // assertions
  default clocking cb @(posedge SYS_CLK iff CE); endclocking
  default disable iff (RESET);

  // the stream trails the sequencer by two cycles: memory read, then output register
  sequence s_load_issue;
    (state_ff == CPCD_LOAD && !LOAD_VALID) [*2] ##1 (state_ff == CPCD_LOAD && LOAD_VALID) [*2];
  endsequence
  sequence s_load_out;
    LOAD_VALID [*2] ##1 !LOAD_VALID;
  endsequence

  property p_cal_start;
    go_cal |=> CAL_START && state_ff == CPCD_CAL && cal_cnt_ff == 4'h0;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("factory calibration did not start");
  property p_cal_end;
    cal_we && cal_cnt_ff == 4'hD |=> state_ff == CPCD_IDLE && CAL_DONE;
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("calibration did not end on byte fourteen");
  property p_cal_wr;
    cal_we |-> mem_we && mem_waddr == cal_cnt_ff[3:2] && mem_wbe == (4'h1 << cal_cnt_ff[1:0]);
  endproperty
  a_cal_wr: assert property (p_cal_wr) else $error("calibration byte stored at wrong place");
  property p_load_seq;
    go_load && param0_ff[CPCD_PRM_FACT] |=> s_load_issue ##1 s_load_out;
  endproperty
  a_load_seq: assert property (p_load_seq) else $error("download stream not four words");
  property p_load_flags;
    go_load |=> FACTORY_CAL_PRESENT == $past(param0_ff[0]) &&
                ALGO_STATE_PRESENT == ($past(param0_ff[0]) && $past(param0_ff[1]));
  endproperty
  a_load_flags: assert property (p_load_flags) else $error("download flags wrong");
  property p_pin_cfg;
    go_pins |=> pin0_cfg_ff == $past(param0_ff[3:0]) && pin1_cfg_ff == $past(param0_ff[7:4]) &&
                state_ff == CPCD_IDLE && !CAL_START;
  endproperty
  a_pin_cfg: assert property (p_pin_cfg) else $error("pin setup not applied");
  property p_drive;
    pin1_cfg_ff == CPCD_PIN_DRV_HI && $stable(pin1_cfg_ff) |=> AUX_PIN1_OE && AUX_PIN1_OUT;
  endproperty
  a_drive: assert property (p_drive) else $error("pin 1 not driven high");
  property p_off;
    pin0_cfg_ff == CPCD_PIN_OFF |=> !AUX_PIN0_OE;
  endproperty
  a_off: assert property (p_off) else $error("disabled pin driven");
  property p_inh_lo;
    pin0_cfg_ff == CPCD_PIN_INH_LO && !sync2_ff[0] && !COLLECT_BLOCK |=> COLLECT_BLOCK && MEAS_ABORT;
  endproperty
  a_inh_lo: assert property (p_inh_lo) else $error("low inhibit did not abort");
  property p_inh_hi;
    COLLECT_BLOCK && pin1_cfg_ff == CPCD_PIN_INH_HI && !sync2_ff[1] &&
      !(pin0_cfg_ff == CPCD_PIN_INH_LO && !sync2_ff[0]) && !(pin0_cfg_ff == CPCD_PIN_INH_HI && sync2_ff[0])
      |=> MEAS_RESTART && !COLLECT_BLOCK ##1 !MEAS_RESTART;
  endproperty
  a_inh_hi: assert property (p_inh_hi) else $error("high inhibit release did not restart");
endmodule : cpcd_decoder

// ===== tb/cpcd_cal_engine.sv
// behavioural calibration engine answering a run start with fourteen result bytes
module cpcd_cal_engine (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // run control
  input  wire logic       start,
  input  wire logic [3:0] gap,
  input  wire logic [7:0] base,
  // result bytes
  output logic            vld,
  output logic      [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // =========================================================
  // idle byte lines toggle so a stale byte never passes for data
  initial begin
    vld = 1'b0;
    byte_o = 8'h00;
    forever begin
      @(posedge clk);
      {vld, byte_o} <= {1'b0, ~byte_o};
      if (start === 1'b1 && rst === 1'b0) begin
        for (int n = 0; n < 14; n++) begin
          repeat (gap) begin
            @(posedge clk);
            {vld, byte_o} <= {1'b0, ~byte_o};
          end
          @(posedge clk);
          {vld, byte_o} <= {1'b1, base + 8'(n)};
        end
      end
    end
  end
endmodule : cpcd_cal_engine

// ===== tb/cpcd_decoder_tb.sv
// self-checking bench for the calibration and pin command decoder
module cpcd_decoder_tb import cpcd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // =========================================================
  logic        clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, lz = 0, e0 = 1, e1 = 0;
  logic [7:0]  awa = 0, ara = 0, base = 0, p;
  logic [7:0]  pl[3] = '{8'h03, 8'h01, 8'h00};
  logic [31:0] d, rq, cw[4], lw[4];
  logic [3:0]  gap = 0;
  logic [1:0]  r;
  int          n_fail = 0, check_count = 0, cyc = 0, nab = 0, nrs = 0, nld = 0, a0, r0;
  wire         awr, wrd, bv, arr, rv, cst, cbv, cdn, lv, fp, ap, o0, oe0, o1, oe1, mab, mrs, blk;
  wire [1:0]   brs, rrs, li;
  wire [31:0]  rdt, lwd;
  wire [7:0]   cb;
  // pin level resolves between decoder drive and the outside source
  wire         p0 = oe0 ? o0 : e0;
  wire         p1 = oe1 ? o1 : e1;
  cpcd_decoder uut (.SYS_CLK(clk), .RESET(rst), .CE(1'b1), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(d), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(brs), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .CAL_START(cst), .CAL_BYTE_VALID(cbv), .CAL_BYTE(cb), .CAL_DONE(cdn), .LOAD_VALID(lv),
    .LOAD_INDEX(li), .LOAD_WORD(lwd), .FACTORY_CAL_PRESENT(fp), .ALGO_STATE_PRESENT(ap),
    .LASER_PULSE(lz), .AUX_PIN0_IN(p0), .AUX_PIN0_OUT(o0), .AUX_PIN0_OE(oe0), .AUX_PIN1_IN(p1),
    .AUX_PIN1_OUT(o1), .AUX_PIN1_OE(oe1), .MEAS_ABORT(mab), .MEAS_RESTART(mrs), .COLLECT_BLOCK(blk));
  cpcd_cal_engine eng (.clk(clk), .rst(rst), .start(cst), .gap(gap), .base(base), .vld(cbv), .byte_o(cb));
  initial forever #5 clk = ~clk;
  // =========================================================
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {awa, d, awv, wv, br} <= {a, v, 3'b111};
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    chk("bresp", brs, CPCD_RESP_OKAY);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] q, output logic [1:0] s);
    @(posedge clk);
    {ara, arv, rr} <= {a, 2'b11};
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    {q, s} = {rdt, rrs};
    rr <= 1'b0;
  endtask : rreg
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic [1:0]  s;
    rreg(a, q, s);
    chk(nm, q, e);
    chk("rresp", s, CPCD_RESP_OKAY);
  endtask : rchk
  // {oe, out} that a pin code should give
  function automatic logic [1:0] pin_exp(input logic [3:0] c, input logic las);
    case (c)
      CPCD_PIN_LASER:  return {1'b1, las};
      CPCD_PIN_DRV_LO: return 2'b10;
      CPCD_PIN_DRV_HI: return 2'b11;
      default:         return 2'b00;
    endcase
  endfunction : pin_exp
  function automatic logic [31:0] calw(input logic [7:0] b, input int w);
    logic [31:0] v;
    for (int i = 0; i < 4; i++) v[8*i +: 8] = b + 8'(4 * w + i);
    return (w == 3) ? (v & CPCD_TAIL_MASK) : v;
  endfunction : calw
  // =========================================================
  always @(posedge clk) begin
    cyc <= cyc + 1;
    nab <= nab + int'(mab === 1'b1);
    nrs <= nrs + int'(mrs === 1'b1);
    if (lv === 1'b1) begin
      lw[li] <= lwd;
      nld <= nld + 1;
    end
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(38));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rchk("command", CPCD_OFS_COMMAND, 0);
    chk("pin0 reset", {oe0, o0}, 2'b10);
    for (int c = 0; c < 10; c++) begin
      p[3:0] = (c < 6) ? 4'(c) : 4'($urandom_range(5));
      p[7:4] = 4'h5 - p[3:0];
      lz <= 1'($urandom_range(1));
      wreg(CPCD_OFS_PARAM0, p);
      wreg(CPCD_OFS_COMMAND, CPCD_CMD_PIN_CFG);
      repeat (3) @(posedge clk);
      chk("pin0", {oe0, o0}, pin_exp(p[3:0], lz));
      chk("pin1", {oe1, o1}, pin_exp(p[7:4], lz));
    end
    $display("test pins done");
    wreg(CPCD_OFS_PARAM0, 8'h21);
    wreg(CPCD_OFS_COMMAND, CPCD_CMD_PIN_CFG);
    repeat (6) @(posedge clk);
    {a0, r0} = {nab, nrs};
    for (int k = 0; k < 4; k++) begin
      if (k < 2) e0 <= k[0];
      else e1 <= ~k[0];
      // one edge beyond the block change so the pulse counters have taken the pulse
      repeat (5) @(posedge clk);
      chk("block", blk, !k[0]);
      chk("abort", nab, a0 + (k + 2) / 2);
      chk("restart", nrs, r0 + (k + 1) / 2);
    end
    $display("test inhibit done");
    for (int k = 0; k < 2; k++) begin
      base <= 8'($urandom);
      gap <= k ? 4'($urandom_range(7, 1)) : 4'h0;
      wreg(CPCD_OFS_COMMAND, CPCD_CMD_FACT_CAL);
      do @(posedge clk); while (cdn !== 1'b1);
      for (int w = 0; w < 4; w++) rchk("cal word", 8'h20 + 8'(4 * w), calw(base, w));
    end
    $display("test calibration done");
    for (int w = 0; w < 4; w++) begin
      cw[w] = $urandom;
      wreg(8'h20 + 8'(4 * w), cw[w]);
    end
    foreach (pl[i]) begin
      a0 = nld;
      wreg(CPCD_OFS_PARAM0, pl[i]);
      wreg(CPCD_OFS_COMMAND, CPCD_CMD_LOAD_CAL);
      repeat (8) @(posedge clk);
      chk("factory", fp, pl[i][0]);
      chk("algo", ap, pl[i][1]);
      chk("words", nld - a0, pl[i][0] ? 4 : 0);
      for (int w = 0; w < 4; w++) chk("load", lw[w], (w == 3) ? (cw[w] & CPCD_TAIL_MASK) : cw[w]);
    end
    // last download had no factory flag: done and calibration done set, flags clear
    rchk("status", CPCD_OFS_STATUS, 32'h0000_0012);
    $display("test download done");
    rreg(8'h40, rq, r);
    chk("unmapped", r, CPCD_RESP_SLVERR);
    chk("unmapped data", rq, 32'h0000_0000);
    report_and_stop();
  end
endmodule : cpcd_decoder_tb
